// file: include/gain_cal_consts.svh
/*
 Constants for the gain calibration and current source register slice.
 Assumes inclusion by bare name from the design file.
*/
`ifndef GAIN_CAL_CONSTS_SVH
`define GAIN_CAL_CONSTS_SVH

// Register indices; byte address is four times the index
`define GC_IDX_LOW 6'h0a
`define GC_IDX_MID 6'h0b
`define GC_IDX_HIGH 6'h0c
`define GC_IDX_ROUTE 6'h0d
`define GC_IDX_LEVEL 6'h0e

// Reset values
`define GC_RST_LOW 8'h00
`define GC_RST_MID 8'h00
`define GC_RST_HIGH 8'h40
`define GC_RST_ROUTE 8'hbb
`define GC_RST_LEVEL 8'h00

// Field positions
`define GC_FLD_FIRST 3:0
`define GC_FLD_SECOND 7:4

// Arithmetic
`define GC_UNITY 24'h400000
`define GC_GAIN_SHIFT 22
`define GC_OFS_SHIFT 8

// Route and level codes
`define GC_ROUTE_COMMON 4'ha
`define GC_ROUTE_NONE 4'hb
`define GC_LEVEL_OFF 4'h0

// Bus responses
`define GC_RESP_OKAY 2'b00
`define GC_RESP_SLVERR 2'b10

`endif

// file: include/gain_cal_pkg.sv
/*
 Types for the gain calibration and current source register slice.
 Assumes the constants header sits in the include path.
*/
package gain_cal_pkg;

    // What one excitation source is told to do
    typedef struct packed {
        logic [10:0] pin_sel;
        logic [11:0] level_ua;
    } source_drive_s;

    // The five stored bytes
    typedef struct packed {
        logic [7:0] low;
        logic [7:0] mid;
        logic [7:0] high;
        logic [7:0] route;
        logic [7:0] level;
    } reg_bank_s;

    // Write channel progress
    typedef enum logic [1:0] {
        WR_COLLECT = 2'b01,
        WR_RESP = 2'b10
    } wr_state_e;

endpackage

// file: rtl/gain_cal_and_current_source_regs.sv
/*
 Full-scale gain calibration, offset/gain correction path and excitation
 current source registers behind an AXI4-Lite slave.
 Assumes one clock, synchronous inputs, and the offset word from elsewhere.
*/
`timescale 1ns/10ps
`include "gain_cal_consts.svh"

module gain_cal_and_current_source_regs
    import gain_cal_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Conversion path
    input wire logic [31:0] conv_data_i,
    input wire logic conv_valid_i,
    input wire logic [23:0] offset_cal_word_i,
    output logic [31:0] result_o,
    output logic result_valid_o,
    // Excitation sources and full-scale gain word
    output source_drive_s first_current_source_o,
    output source_drive_s second_current_source_o,
    output logic [23:0] full_scale_gain_word_o
);

    // Index is taken from address bits 7:2, so those bits must exist
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
        $error("ADDR_W must be 8 to 32");
    end

    // Mapped index check, shared by read and write decode
    function automatic logic idx_hit(input logic [5:0] idx);
        idx_hit = (idx >= `GC_IDX_LOW) && (idx <= `GC_IDX_LEVEL);
    endfunction

    // Route code to one-hot pin select; reserved and none give no pin
    function automatic logic [10:0] route_dec(input logic [3:0] code);
        route_dec = 11'h000;
        if (code <= 4'h9) begin
            route_dec = 11'h001 << code;
        end else if (code == `GC_ROUTE_COMMON) begin
            route_dec = 11'h400;
        end
    endfunction

    // Level code to microamps; reserved codes read as off
    function automatic logic [11:0] level_dec(input logic [3:0] code);
        case (code)
            4'h1: level_dec = 12'h032;
            4'h2: level_dec = 12'h064;
            4'h3: level_dec = 12'h0fa;
            4'h4: level_dec = 12'h1f4;
            4'h5: level_dec = 12'h2ee;
            4'h6: level_dec = 12'h3e8;
            4'h7: level_dec = 12'h5dc;
            4'h8: level_dec = 12'h7d0;
            4'h9: level_dec = 12'h9c4;
            4'ha: level_dec = 12'hbb8;
            default: level_dec = 12'h000;
        endcase
    endfunction

    // Clamp a wide signed value into 32 bits
    function automatic logic [31:0] sat32(input logic signed [35:0] v);
        if (v > 36'sh007fffffff) begin
            sat32 = 32'h7fffffff;
        end else if (v < -36'sh0080000000) begin
            sat32 = 32'h80000000;
        end else begin
            sat32 = v[31:0];
        end
    endfunction

    reg_bank_s regs, next_regs;
    wr_state_e wr_state, next_wr_state;
    logic aw_held, next_aw_held;
    logic w_held, next_w_held;
    logic [5:0] aw_idx, next_aw_idx;
    logic [7:0] w_byte, next_w_byte;
    logic w_lane0, next_w_lane0;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [1:0] rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic wr_fire;
    logic [5:0] ar_idx;

    assign ar_idx = s_axi_araddr_i[7:2];
    assign wr_fire = (wr_state == WR_COLLECT) && aw_held && w_held;

    // Channels accept independently; response follows both
    assign s_axi_awready_o = (wr_state == WR_COLLECT) && !aw_held;
    assign s_axi_wready_o = (wr_state == WR_COLLECT) && !w_held;
    assign s_axi_arready_o = !rvalid;
    assign s_axi_bvalid_o = bvalid;
    assign s_axi_bresp_o = bresp;
    assign s_axi_rvalid_o = rvalid;
    assign s_axi_rresp_o = rresp;
    assign s_axi_rdata_o = rdata;

    // Register file and bus next state
    always_comb begin
        next_regs = regs;
        next_wr_state = wr_state;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_idx = aw_idx;
        next_w_byte = w_byte;
        next_w_lane0 = w_lane0;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            next_aw_held = 1'b1;
            next_aw_idx = s_axi_awaddr_i[7:2];
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            next_w_held = 1'b1;
            next_w_byte = s_axi_wdata_i[7:0];
            next_w_lane0 = s_axi_wstrb_i[0];
        end
        case (wr_state)
            WR_COLLECT: begin
                if (wr_fire) begin
                    next_bvalid = 1'b1;
                    next_bresp = idx_hit(aw_idx) ? `GC_RESP_OKAY : `GC_RESP_SLVERR;
                    next_wr_state = WR_RESP;
                    // Only byte lane 0 carries register data
                    if (w_lane0) begin
                        case (aw_idx)
                            `GC_IDX_LOW: next_regs.low = w_byte;
                            `GC_IDX_MID: next_regs.mid = w_byte;
                            `GC_IDX_HIGH: next_regs.high = w_byte;
                            `GC_IDX_ROUTE: next_regs.route = w_byte;
                            `GC_IDX_LEVEL: next_regs.level = w_byte;
                            default: next_regs = regs;
                        endcase
                    end
                end
            end
            WR_RESP: begin
                if (s_axi_bready_i) begin
                    next_bvalid = 1'b0;
                    next_aw_held = 1'b0;
                    next_w_held = 1'b0;
                    next_wr_state = WR_COLLECT;
                end
            end
            default: next_wr_state = WR_COLLECT;
        endcase
        // Reads return stored codes, reserved ones included
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            next_rvalid = 1'b1;
            next_rresp = idx_hit(ar_idx) ? `GC_RESP_OKAY : `GC_RESP_SLVERR;
            case (ar_idx)
                `GC_IDX_LOW: next_rdata = {24'h000000, regs.low};
                `GC_IDX_MID: next_rdata = {24'h000000, regs.mid};
                `GC_IDX_HIGH: next_rdata = {24'h000000, regs.high};
                `GC_IDX_ROUTE: next_rdata = {24'h000000, regs.route};
                `GC_IDX_LEVEL: next_rdata = {24'h000000, regs.level};
                default: next_rdata = 32'h00000000;
            endcase
        end else if (rvalid && s_axi_rready_i) begin
            next_rvalid = 1'b0;
        end
    end

    // Register file and bus state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            regs <= {`GC_RST_LOW, `GC_RST_MID, `GC_RST_HIGH, `GC_RST_ROUTE, `GC_RST_LEVEL};
            wr_state <= WR_COLLECT;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= 6'h00;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `GC_RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= `GC_RESP_OKAY;
            rdata <= 32'h00000000;
        end else begin
            regs <= next_regs;
            wr_state <= next_wr_state;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_idx <= next_aw_idx;
            w_byte <= next_w_byte;
            w_lane0 <= next_w_lane0;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
        end
    end

    logic [23:0] fs_word;
    assign fs_word = {regs.high, regs.mid, regs.low};
    assign full_scale_gain_word_o = fs_word;

    // Correction path: offset first, then gain; 33 bits avoid wrap on subtract
    logic signed [32:0] corr, next_corr;
    logic corr_valid, next_corr_valid;
    logic [31:0] result, next_result;
    logic result_valid, next_result_valid;
    logic signed [57:0] prod;

    // Zero-extended so the word never reads as negative
    assign prod = corr * $signed({1'b0, fs_word});
    assign result_o = result;
    assign result_valid_o = result_valid;

    always_comb begin
        next_corr = $signed({conv_data_i[31], conv_data_i})
            - $signed({offset_cal_word_i[23], offset_cal_word_i, 8'h00});
        next_corr_valid = conv_valid_i;
        next_result = sat32(prod[57:`GC_GAIN_SHIFT]);
        next_result_valid = corr_valid;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            corr <= 33'sh000000000;
            corr_valid <= 1'b0;
            result <= 32'h00000000;
            result_valid <= 1'b0;
        end else begin
            corr <= next_corr;
            corr_valid <= next_corr_valid;
            result <= next_result;
            result_valid <= next_result_valid;
        end
    end

    // Source drive; a reserved code zeroes only its own field, pin select or level
    source_drive_s first_drive, next_first_drive;
    source_drive_s second_drive, next_second_drive;
    assign first_current_source_o = first_drive;
    assign second_current_source_o = second_drive;

    always_comb begin
        next_first_drive.pin_sel = route_dec(regs.route[`GC_FLD_FIRST]);
        next_first_drive.level_ua = level_dec(regs.level[`GC_FLD_FIRST]);
        next_second_drive.pin_sel = route_dec(regs.route[`GC_FLD_SECOND]);
        next_second_drive.level_ua = level_dec(regs.level[`GC_FLD_SECOND]);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            first_drive <= '0;
            second_drive <= '0;
        end else begin
            first_drive <= next_first_drive;
            second_drive <= next_second_drive;
        end
    end

    // Checks
    AST_ASSEMBLE_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_fire && w_lane0 && aw_idx == `GC_IDX_HIGH |=> fs_word[23:16] == $past(w_byte))
        else $error("High gain byte not stored");
    AST_UNSIGNED_WORD: assert property (@(posedge clk_i) disable iff (rst_i)
        corr_valid && corr > 0 && fs_word[23] |=> !result[31])
        else $error("Large gain word treated as negative");
    AST_UNITY_GAIN: assert property (@(posedge clk_i) disable iff (rst_i)
        corr_valid && fs_word == `GC_UNITY |=> result == sat32(36'($past(corr))))
        else $error("Unity word does not pass value through");
    AST_LATENCY: assert property (@(posedge clk_i) disable iff (rst_i)
        conv_valid_i |-> ##2 result_valid)
        else $error("Result not two cycles after conversion");
    AST_RESET_WORD: assert property (@(posedge clk_i)
        rst_i |=> fs_word == `GC_UNITY)
        else $error("Gain word reset wrong");
    AST_OFFSET_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
        conv_valid_i && offset_cal_word_i == 24'h000000
            |=> corr == $signed({$past(conv_data_i[31]), $past(conv_data_i)}))
        else $error("Zero offset altered result");
    AST_OFFSET_ALIGN: assert property (@(posedge clk_i) disable iff (rst_i)
        conv_valid_i && conv_data_i == 32'h00000000 && offset_cal_word_i == 24'hffffff |=> corr == 33'sh000000100)
        else $error("Offset not aligned as two's complement");
    AST_ROUTE_RESET: assert property (@(posedge clk_i)
        rst_i |=> regs.route == `GC_RST_ROUTE)
        else $error("Route reset wrong");
    AST_COMMON_PIN: assert property (@(posedge clk_i) disable iff (rst_i)
        regs.route[3:0] == `GC_ROUTE_COMMON |=> first_drive.pin_sel == 11'h400)
        else $error("Common input not selected");
    AST_LEVEL_RESET: assert property (@(posedge clk_i)
        rst_i |=> regs.level == `GC_RST_LEVEL ##1 first_drive.level_ua == 12'h000)
        else $error("Level reset wrong");
    AST_LEVEL_TOP: assert property (@(posedge clk_i) disable iff (rst_i)
        regs.level[7:4] == 4'ha |=> second_drive.level_ua == 12'hbb8)
        else $error("Top level code wrong");
    AST_RESERVED_PARK: assert property (@(posedge clk_i) disable iff (rst_i)
        regs.route[3:0] > `GC_ROUTE_NONE && regs.level[3:0] > 4'ha |=> first_drive == '0)
        else $error("Reserved code drove a source");

    COV_WRITE: cover property (@(posedge clk_i) disable iff (rst_i) bvalid && s_axi_bready_i);
    COV_READ: cover property (@(posedge clk_i) disable iff (rst_i) rvalid && s_axi_rready_i);
    COV_SCALED: cover property (@(posedge clk_i) disable iff (rst_i) result_valid && fs_word != `GC_UNITY);
    COV_RESERVED: cover property (@(posedge clk_i) disable iff (rst_i) regs.route[7:4] == 4'hf);

endmodule // gain_cal_and_current_source_regs

// file: sim/tb_gain_cal_and_current_source_regs.sv
/*
 Self-checking bench for the gain calibration and current source slice.
 Assumes the package and the constants header are compiled first.
*/
`timescale 1ns/10ps

module tb_gain_cal_and_current_source_regs;
    import gain_cal_pkg::*;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, conv_data = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic conv_valid = 1'b0;
    logic [23:0] ofs_word = 24'h0, gain_exp = 24'h400000;
    logic awready, wready, bvalid, arready, rvalid, res_valid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, res, rd;
    source_drive_s src1, src2;
    logic [23:0] fs_word;
    logic [31:0] expq[$];
    int errors = 0, comparisons = 0, cycles = 0, seed = 38004;
    logic [11:0] ua_tab [16] = '{12'h000, 12'h032, 12'h064, 12'h0fa, 12'h1f4, 12'h2ee, 12'h3e8, 12'h5dc,
        12'h7d0, 12'h9c4, 12'hbb8, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000};
    logic [7:0] addr_tab [5] = '{8'h28, 8'h2c, 8'h30, 8'h34, 8'h38};
    logic [7:0] rst_tab [5] = '{8'h00, 8'h00, 8'h40, 8'hbb, 8'h00};

    gain_cal_and_current_source_regs dut (.clk_i(clk_i), .rst_i(rst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .conv_data_i(conv_data), .conv_valid_i(conv_valid), .offset_cal_word_i(ofs_word),
        .result_o(res), .result_valid_o(res_valid),
        .first_current_source_o(src1), .second_current_source_o(src2), .full_scale_gain_word_o(fs_word));

    // 250 MHz clock
    always #2 clk_i = ~clk_i;

    // Hang guard, generous against roughly 500 cycles of tests
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Address and data offered together, each released when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk_i);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1)
            @(posedge clk_i);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a);
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk_i); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1)
            @(posedge clk_i);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    function automatic logic [22:0] exp_src(input logic [3:0] rt, input logic [3:0] lv);
        logic [10:0] p;
        p = (rt <= 4'h9) ? (11'h001 << rt) : ((rt == 4'ha) ? 11'h400 : 11'h000);
        return {p, ua_tab[lv]};
    endfunction

    // Offset aligned up by 8, gain word unsigned, floor shift, then saturation
    function automatic logic [31:0] exp_res(input logic [31:0] c, input logic [23:0] o, input logic [23:0] g);
        logic signed [32:0] d;
        logic signed [57:0] p;
        d = $signed({c[31], c}) - $signed({o[23], o, 8'h00});
        p = (d * $signed({1'b0, g})) >>> 22;
        if (p > 58'sh7fffffff)
            return 32'h7fffffff;
        if (p < -58'sh80000000)
            return 32'h80000000;
        return p[31:0];
    endfunction

    // Results pair with pulses in issue order
    always @(posedge clk_i) begin
        if (res_valid === 1'b1) begin
            if (expq.size() == 0)
                check(32'h1, 32'h0);
            else
                check(res, expq.pop_front());
        end
    end

    task automatic send_conv(input logic [31:0] c, input logic [23:0] o);
        @(posedge clk_i);
        conv_data <= c;
        ofs_word <= o;
        conv_valid <= 1'b1;
        expq.push_back(exp_res(c, o, gain_exp));
    endtask

    task automatic check_defaults();
        for (int i = 0; i < 5; i++) begin
            axi_read(addr_tab[i]);
            check(rd, {24'h0, rst_tab[i]});
        end
        check(fs_word, 24'h400000);
        check(src1, 23'h0);
        check(src2, 23'h0);
        $display("test defaults done");
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        check_defaults();
        // Unmapped places and a write with byte lane 0 disabled
        axi_write(8'h3c, 32'h000000aa, 4'hf);
        check(resp, 2'b10);
        axi_read(8'h24);
        check(rd, 32'h0);
        check(resp, 2'b10);
        axi_write(8'h34, 32'h00000012, 4'he);
        check(resp, 2'b00);
        axi_read(8'h34);
        check(rd, 32'h000000bb);
        $display("test unmapped done");
        // Every route and level code on both sources
        for (int i = 0; i < 16; i++) begin
            axi_write(8'h34, {24'h0, 4'(15 - i), 4'(i)}, 4'hf);
            axi_write(8'h38, {24'h0, 4'(i + 5), 4'(i)}, 4'hf);
            @(posedge clk_i);
            #1;
            check(src1, exp_src(4'(i), 4'(i)));
            check(src2, exp_src(4'(15 - i), 4'(i + 5)));
            axi_read(8'h34);
            check(rd, {24'h0, 4'(15 - i), 4'(i)});
            axi_read(8'h38);
            check(rd, {24'h0, 4'(i + 5), 4'(i)});
        end
        $display("test sources done");
        // Gain words: unity, top bit set, then random
        for (int k = 0; k < 6; k++) begin
            gain_exp = (k == 0) ? 24'h400000 : ((k == 1) ? 24'hffffff : 24'($random(seed)));
            axi_write(8'h28, {24'h0, gain_exp[7:0]}, 4'hf);
            axi_write(8'h2c, {24'h0, gain_exp[15:8]}, 4'hf);
            axi_write(8'h30, {24'h0, gain_exp[23:16]}, 4'hf);
            axi_read(8'h30);
            check(rd, {24'h0, gain_exp[23:16]});
            check(fs_word, gain_exp);
            send_conv(32'h7fffffff, 24'h800000);
            send_conv(32'h80000000, 24'h7fffff);
            send_conv(32'h00000000, 24'h000000);
            send_conv(32'h00000000, 24'hffffff);
            for (int j = 0; j < 8; j++)
                send_conv($random(seed), 24'($random(seed)));
            @(posedge clk_i);
            conv_valid <= 1'b0;
            repeat (4) @(posedge clk_i);
            check(expq.size(), 0);
        end
        $display("test gain path done");
        // Reset in mid-run brings back the defaults
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        gain_exp = 24'h400000;
        check_defaults();
        report_and_stop();
    end

endmodule // tb_gain_cal_and_current_source_regs
